// File: hdl/dcp_pkg.sv
/*
 * Package of the DDR CMOS data port with powerdown control: register
 * offsets, field positions, reset values, pattern codes and carrier types.
 * Assumes one core clock; the reference, host clock and sleep pins are
 * sampled asynchronous levels.
 */
// Operation
// - receive data is DDR; channel A valid at forwarded rising edge, B at falling.
// - forwarded receive clock runs at the reference clock frequency.
// - test patterns act only while value 08 sits in register 042.
// - selectors 031/037: 01 zeros, 02 ones, 03 toggle, 04 ramp, 05 custom.
// - ramp pattern counts linearly from minimum to maximum code.
// - shared 12-bit custom code from 03F bits 5..0 and 040 bits 7..2.
// - custom pattern holds the programmed code constant on the output.
// - transmit words are two's complement, passed through unchanged.
// - host transmit data latched: channel A on rising, B on falling clock edge.
// - value 05 in register 106 selects two-times interpolation.
// - register 207 picks pin-triggered powerdown kind; pin level asserts it.
// - global powerdown shuts down most functions.
// - fast-recovery powerdown puts receive and transmit into light sleep.
// - transmit-only powerdown stops transmit, receive stays active.
// - receive-only powerdown stops receive, transmit stays active.
// - bit 7 of register 207 triggers powerdown by software; pin held low.
// - receive words are 12-bit two's complement, 800 to 7ff.
package dcp_pkg;

	localparam int ADDR_W = 10;
	localparam int DATA_W = 8;
	localparam int WORD_W = 12;

	// ************************************************************
	// register offsets
	// ************************************************************
	localparam logic [ADDR_W-1:0] OFS_PAT_A = 10'h031;
	localparam logic [ADDR_W-1:0] OFS_PAT_B = 10'h037;
	localparam logic [ADDR_W-1:0] OFS_CUST_HI = 10'h03f;
	localparam logic [ADDR_W-1:0] OFS_CUST_LO = 10'h040;
	localparam logic [ADDR_W-1:0] OFS_TP_EN = 10'h042;
	localparam logic [ADDR_W-1:0] OFS_INTERP = 10'h106;
	localparam logic [ADDR_W-1:0] OFS_PWRDN = 10'h207;

	// ************************************************************
	// reset values and field codes
	// ************************************************************
	localparam logic [DATA_W-1:0] RST_CFG = 8'h00;
	localparam logic [DATA_W-1:0] TP_EN_VALUE = 8'h08;
	localparam logic [DATA_W-1:0] PAT_ZERO = 8'h01;
	localparam logic [DATA_W-1:0] PAT_ONES = 8'h02;
	localparam logic [DATA_W-1:0] PAT_TOGGLE = 8'h03;
	localparam logic [DATA_W-1:0] PAT_RAMP = 8'h04;
	localparam logic [DATA_W-1:0] PAT_CUSTOM = 8'h05;
	localparam logic [DATA_W-1:0] INTERP_2X = 8'h05;
	localparam int PD_SW_BIT = 7;
	localparam int PD_FAST_BIT = 6;
	localparam int PD_GLOBAL_BIT = 5;
	localparam int PD_RX_BIT = 2;
	localparam int PD_TX_BIT = 1;
	localparam int CUST_HI_MSB = 5;
	localparam int CUST_HI_LSB = 0;
	localparam int CUST_LO_MSB = 7;
	localparam int CUST_LO_LSB = 2;
	localparam logic [WORD_W-1:0] CODE_MIN = 12'h800;
	localparam logic [WORD_W-1:0] CODE_ZERO = 12'h000;
	localparam logic [WORD_W-1:0] CODE_ONES = 12'hfff;
	localparam logic [WORD_W-1:0] RAMP_STEP = 12'h001;

	// ************************************************************
	// carriers
	// ************************************************************
	typedef struct packed {
		logic [DATA_W-1:0] pat_a;
		logic [DATA_W-1:0] pat_b;
		logic [DATA_W-1:0] cust_hi;
		logic [DATA_W-1:0] cust_lo;
		logic [DATA_W-1:0] tp_en;
		logic [DATA_W-1:0] interp;
		logic [DATA_W-1:0] pwrdn;
	} dcp_cfg_t;

	typedef struct packed {
		logic global_pd;
		logic light_sleep;
		logic rx_off;
		logic tx_off;
	} dcp_pd_t;

	typedef struct packed {
		logic [WORD_W-1:0] word_a;
		logic [WORD_W-1:0] word_b;
	} dcp_pair_t;

endpackage

// File: hdl/dcp_sync.sv
/*
 * Two-flop level synchroniser for a group of asynchronous pins.
 * Assumes the group is sampled as independent levels; only the second
 * stage is visible outside.
 */
`timescale 1ns/10ps
module dcp_sync #(
	parameter int W = 1
) (
	input wire logic clk_i, // core clock
	input wire logic rst_i, // asynchronous reset, active high
	input wire logic [W-1:0] d_i, // asynchronous levels
	output logic [W-1:0] q_o // synchronised levels
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stable;
	} dcp_sync_st_t;

	dcp_sync_st_t st;
	dcp_sync_st_t next_st;

	always_comb
	begin
		next_st.meta = d_i;
		next_st.stable = st.meta;
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			st <= '0;
		end
		else
		begin
			st <= next_st;
		end
	end

	assign q_o = st.stable;
endmodule

// File: hdl/dcp_port.sv
/*
 * DDR CMOS receive/transmit data port with test patterns, interpolation
 * select and powerdown control, with its configuration register port.
 * Assumes converter words arrive on clk_i; reference clock, host clock,
 * host data and sleep pin are asynchronous and at least four core cycles
 * per half period.
 */
`timescale 1ns/10ps
module dcp_port
	import dcp_pkg::*;
(
	input wire logic clk_i, // 200 MHz core clock
	input wire logic rst_i, // asynchronous reset, active high
	input wire logic ref_clock_pos_i, // reference clock, true side
	input wire logic ref_clock_neg_i, // reference clock, complement side
	input wire logic [WORD_W-1:0] adc_a_i, // converter word, channel A
	input wire logic [WORD_W-1:0] adc_b_i, // converter word, channel B
	input wire logic tx_host_clock_i, // host transmit clock pin
	input wire logic [WORD_W-1:0] tx_data_i, // host DDR transmit data pins
	input wire logic sleep_request_pin_i, // powerdown request pin
	input wire logic reg_wr_i, // register write strobe
	input wire logic reg_rd_i, // register read strobe
	input wire logic [ADDR_W-1:0] reg_addr_i, // register address
	input wire logic [DATA_W-1:0] reg_wdata_i, // register write data
	output logic [DATA_W-1:0] reg_rdata_o, // register read data
	output logic [WORD_W-1:0] rx_data_o, // DDR receive data bus
	output logic rx_forwarded_clock_o, // forwarded receive clock
	output logic [WORD_W-1:0] tx_word_a_o, // latched transmit word, channel A
	output logic [WORD_W-1:0] tx_word_b_o, // latched transmit word, channel B
	output logic tx_pair_valid_o, // pulse: new transmit pair
	output logic tx_interp_2x_o, // two-times interpolation selected
	output logic pd_global_o, // global powerdown active
	output logic pd_light_sleep_o, // fast-recovery light sleep active
	output logic rx_path_off_o, // receive path powered down
	output logic tx_path_off_o // transmit path powered down
);
	typedef struct packed {
		dcp_cfg_t cfg;
		dcp_pd_t pd;
		dcp_pair_t tx;
		logic [WORD_W-1:0] b_hold;
		logic [WORD_W-1:0] ramp_a;
		logic [WORD_W-1:0] ramp_b;
		logic tog_a;
		logic tog_b;
		logic [WORD_W-1:0] rx_data;
		logic fwd_clk;
		logic ref_prev;
		logic tx_prev;
		logic tx_valid;
		logic interp_2x;
		logic [DATA_W-1:0] rd_data;
	} dcp_st_t;

	dcp_st_t st;
	dcp_st_t next_st;
	logic [1:0] ref_pair_s;
	logic [WORD_W:0] tx_group_s;
	logic pin_s;
	logic ref_s;
	logic txc_s;
	logic [WORD_W-1:0] txd_s;
	logic ref_rise;
	logic ref_fall;
	logic tx_rise;
	logic tx_fall;
	logic tp_on;
	logic pd_trig;
	logic [WORD_W-1:0] cust_code;

	// ************************************************************
	// pin synchronisers
	// ************************************************************
	dcp_sync #(.W(2)) u_sync_ref (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.d_i({ref_clock_neg_i, ref_clock_pos_i}),
		.q_o(ref_pair_s)
	);
	// host clock and data share one synchroniser so their latency matches
	dcp_sync #(.W(WORD_W + 1)) u_sync_tx (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.d_i({tx_host_clock_i, tx_data_i}),
		.q_o(tx_group_s)
	);
	dcp_sync #(.W(1)) u_sync_pin (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.d_i(sleep_request_pin_i),
		.q_o(pin_s)
	);

	assign ref_s = ref_pair_s[0] & ~ref_pair_s[1];
	assign txc_s = tx_group_s[WORD_W];
	assign txd_s = tx_group_s[WORD_W-1:0];
	assign ref_rise = ref_s & ~st.ref_prev;
	assign ref_fall = ~ref_s & st.ref_prev;
	assign tx_rise = txc_s & ~st.tx_prev;
	assign tx_fall = ~txc_s & st.tx_prev;
	assign tp_on = (st.cfg.tp_en == TP_EN_VALUE);
	assign cust_code = {st.cfg.cust_hi[CUST_HI_MSB:CUST_HI_LSB],
		st.cfg.cust_lo[CUST_LO_MSB:CUST_LO_LSB]};
	assign pd_trig = pin_s | st.cfg.pwrdn[PD_SW_BIT];

	// ************************************************************
	// pattern selection
	// ************************************************************
	function automatic logic [WORD_W-1:0] pick(
		input logic on,
		input logic [DATA_W-1:0] pat,
		input logic [WORD_W-1:0] adc,
		input logic [WORD_W-1:0] ramp,
		input logic tog,
		input logic [WORD_W-1:0] cust
	);
		logic [WORD_W-1:0] w;
		w = adc;
		if (on)
		begin
			case (pat)
				PAT_ZERO: w = CODE_ZERO;
				PAT_ONES: w = CODE_ONES;
				PAT_TOGGLE: w = tog ? CODE_ONES : CODE_ZERO;
				PAT_RAMP: w = ramp;
				PAT_CUSTOM: w = cust;
				default: w = adc;
			endcase
		end
		return w;
	endfunction

	// ************************************************************
	// next state
	// ************************************************************
	always_comb
	begin
		next_st = st;
		next_st.ref_prev = ref_s;
		next_st.tx_prev = txc_s;
		next_st.tx_valid = 1'b0;
		// configuration only changes on a write
		if (reg_wr_i)
		begin
			case (reg_addr_i)
				OFS_PAT_A: next_st.cfg.pat_a = reg_wdata_i;
				OFS_PAT_B: next_st.cfg.pat_b = reg_wdata_i;
				OFS_CUST_HI: next_st.cfg.cust_hi = reg_wdata_i;
				OFS_CUST_LO: next_st.cfg.cust_lo = reg_wdata_i;
				OFS_TP_EN: next_st.cfg.tp_en = reg_wdata_i;
				OFS_INTERP: next_st.cfg.interp = reg_wdata_i;
				OFS_PWRDN: next_st.cfg.pwrdn = reg_wdata_i;
				default: ;
			endcase
		end
		if (reg_rd_i)
		begin
			case (reg_addr_i)
				OFS_PAT_A: next_st.rd_data = st.cfg.pat_a;
				OFS_PAT_B: next_st.rd_data = st.cfg.pat_b;
				OFS_CUST_HI: next_st.rd_data = st.cfg.cust_hi;
				OFS_CUST_LO: next_st.rd_data = st.cfg.cust_lo;
				OFS_TP_EN: next_st.rd_data = st.cfg.tp_en;
				OFS_INTERP: next_st.rd_data = st.cfg.interp;
				OFS_PWRDN: next_st.rd_data = st.cfg.pwrdn;
				default: next_st.rd_data = '0;
			endcase
		end
		next_st.interp_2x = (st.cfg.interp == INTERP_2X);

		// powerdown kind from the register, trigger from pin or bit 7
		next_st.pd.global_pd = pd_trig & st.cfg.pwrdn[PD_GLOBAL_BIT];
		next_st.pd.light_sleep = pd_trig & st.cfg.pwrdn[PD_FAST_BIT];
		next_st.pd.tx_off = pd_trig & (st.cfg.pwrdn[PD_GLOBAL_BIT]
			| st.cfg.pwrdn[PD_FAST_BIT] | st.cfg.pwrdn[PD_TX_BIT]);
		next_st.pd.rx_off = pd_trig & (st.cfg.pwrdn[PD_GLOBAL_BIT]
			| st.cfg.pwrdn[PD_FAST_BIT] | st.cfg.pwrdn[PD_RX_BIT]);

		// clock trails data by one cycle to give the host setup margin
		if (st.pd.rx_off)
		begin
			next_st.fwd_clk = 1'b0;
		end
		else
		begin
			next_st.fwd_clk = st.ref_prev;
			if (ref_rise)
			begin
				next_st.rx_data = pick(tp_on, st.cfg.pat_a, adc_a_i, st.ramp_a,
					st.tog_a, cust_code);
				next_st.b_hold = pick(tp_on, st.cfg.pat_b, adc_b_i, st.ramp_b,
					st.tog_b, cust_code);
				// natural 12-bit wrap takes 7ff back to 800
				next_st.ramp_a = (tp_on && st.cfg.pat_a == PAT_RAMP)
					? st.ramp_a + RAMP_STEP : CODE_MIN;
				next_st.ramp_b = (tp_on && st.cfg.pat_b == PAT_RAMP)
					? st.ramp_b + RAMP_STEP : CODE_MIN;
				next_st.tog_a = (tp_on && st.cfg.pat_a == PAT_TOGGLE) & ~st.tog_a;
				next_st.tog_b = (tp_on && st.cfg.pat_b == PAT_TOGGLE) & ~st.tog_b;
			end
			else if (ref_fall)
			begin
				next_st.rx_data = st.b_hold;
			end
		end

		// transmit words stay two's complement, no reformatting
		if (!st.pd.tx_off)
		begin
			if (tx_rise)
			begin
				next_st.tx.word_a = txd_s;
			end
			if (tx_fall)
			begin
				next_st.tx.word_b = txd_s;
				next_st.tx_valid = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			st <= '0;
			st.cfg <= {7{RST_CFG}};
			st.ramp_a <= CODE_MIN;
			st.ramp_b <= CODE_MIN;
		end
		else
		begin
			st <= next_st;
		end
	end

	// ************************************************************
	// outputs
	// ************************************************************
	assign reg_rdata_o = st.rd_data;
	assign rx_data_o = st.rx_data;
	assign rx_forwarded_clock_o = st.fwd_clk;
	assign tx_word_a_o = st.tx.word_a;
	assign tx_word_b_o = st.tx.word_b;
	assign tx_pair_valid_o = st.tx_valid;
	assign tx_interp_2x_o = st.interp_2x;
	assign pd_global_o = st.pd.global_pd;
	assign pd_light_sleep_o = st.pd.light_sleep;
	assign rx_path_off_o = st.pd.rx_off;
	assign tx_path_off_o = st.pd.tx_off;

	// ************************************************************
	// assertions
	// ************************************************************
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	a_fwd_clk_rise: assert property (
		ref_rise ##1 !st.pd.rx_off |=> st.fwd_clk)
		else $error("forwarded clock did not follow reference rise");
	a_rx_chan_a: assert property (
		ref_rise && !st.pd.rx_off && !tp_on |=> st.rx_data == $past(adc_a_i))
		else $error("channel A word not driven at reference rise");
	a_rx_chan_b: assert property (
		ref_fall && !st.pd.rx_off |=> st.rx_data == $past(st.b_hold))
		else $error("channel B word not driven at reference fall");
	a_pat_ones: assert property (
		ref_rise && !st.pd.rx_off && tp_on && st.cfg.pat_b == PAT_ONES
		|=> st.b_hold == CODE_ONES)
		else $error("all-ones pattern missing");
	a_pat_custom: assert property (
		ref_rise && !st.pd.rx_off && tp_on && st.cfg.pat_a == PAT_CUSTOM
		|=> st.rx_data == {$past(st.cfg.cust_hi[5:0]), $past(st.cfg.cust_lo[7:2])})
		else $error("custom code not on output");
	a_ramp_step: assert property (
		ref_rise && !st.pd.rx_off && tp_on && st.cfg.pat_b == PAT_RAMP
		|=> st.ramp_b == WORD_W'($past(st.ramp_b) + RAMP_STEP)
		&& st.b_hold == $past(st.ramp_b))
		else $error("ramp did not step by one");
	a_tx_latch_a: assert property (
		tx_rise && !st.pd.tx_off |=> st.tx.word_a == $past(txd_s))
		else $error("transmit channel A not latched on rising edge");
	a_interp_sel: assert property (
		reg_wr_i && reg_addr_i == OFS_INTERP && reg_wdata_i == INTERP_2X
		|=> ##1 st.interp_2x)
		else $error("interpolation select not applied");
	a_pd_global: assert property (
		st.cfg.pwrdn == 8'h20 && pin_s |=> st.pd.global_pd && st.pd.rx_off
		&& st.pd.tx_off)
		else $error("global powerdown not entered on pin");
	a_pd_tx_sw: assert property (
		st.cfg.pwrdn == 8'h82 |=> st.pd.tx_off && !st.pd.rx_off)
		else $error("software transmit powerdown wrong");
	a_pd_rx_pin: assert property (
		st.cfg.pwrdn == 8'h04 && !pin_s |=> !st.pd.rx_off)
		else $error("receive powerdown without trigger");
	a_pd_fast: assert property (
		st.cfg.pwrdn == 8'hc0 |=> st.pd.light_sleep && st.pd.rx_off)
		else $error("fast-recovery sleep not entered");
	a_cfg_hold: assert property (
		!reg_wr_i |=> $stable(st.cfg))
		else $error("configuration changed without a write");
endmodule

// File: verif/dcp_host_model.sv
/*
 * Host model for the data port: drives DDR transmit words against its own
 * clock and captures the receive bus on the forwarded clock.
 * Assumes the port samples all host pins as asynchronous levels.
 */
`timescale 1ns/10ps
module dcp_host_model
	import dcp_pkg::*;
(
	input wire logic run_i, // frames enabled
	input wire logic fwd_clk_i, // forwarded receive clock
	input wire logic [WORD_W-1:0] rx_data_i, // receive bus
	output logic host_clk_o, // transmit clock to the port
	output logic [WORD_W-1:0] host_data_o, // transmit data to the port
	output logic [WORD_W-1:0] cap_a_o, // last channel A capture
	output logic [WORD_W-1:0] cap_b_o, // last channel B capture
	output int rx_count_o // complete receive pairs
);
	logic [WORD_W-1:0] word;

	// clock stands low between frames; idle data keeps moving on purpose
	initial
	begin
		host_clk_o = 1'b0;
		host_data_o = 12'h000;
		rx_count_o = 0;
		word = 12'h7fe;
		#3;
		forever
		begin
			if (run_i)
			begin
				host_data_o = word;
				#12;
				host_clk_o = 1'b1;
				#12;
				host_data_o = ~word;
				#12;
				host_clk_o = 1'b0;
				#12;
				word = word + 12'h001;
			end
			else
			begin
				host_data_o = ~host_data_o;
				#12;
			end
		end
	end

	always @(posedge fwd_clk_i)
		cap_a_o <= rx_data_i;

	always @(negedge fwd_clk_i)
	begin
		cap_b_o <= rx_data_i;
		rx_count_o <= rx_count_o + 1;
	end
endmodule

// File: verif/dcp_port_bench.sv
/*
 * Self-checking bench for the data port: register tasks, pattern,
 * transmit and powerdown sequences.
 * Assumes the host model beside it and a free-running reference clock.
 */
`timescale 1ns/10ps
module dcp_port_bench;
	import dcp_pkg::*;
	logic clk_i, rst_i, ref_p, pin, wr, rd, run, fwd, hclk, tvalid;
	logic i2x, pg, pl, prx, ptx;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata, rdata, v;
	logic [WORD_W-1:0] adc_a, adc_b, rxd, txa, txb, hdata, cap_a, cap_b;
	logic [WORD_W-1:0] a0, b0, a1, b1;
	int rx_count, tx_count, ref_count, fail_count, comparisons, r, n, d;
	logic [ADDR_W-1:0] offs [7] = '{OFS_PAT_A, OFS_PAT_B, OFS_CUST_HI,
		OFS_CUST_LO, OFS_TP_EN, OFS_INTERP, OFS_PWRDN};
	logic [DATA_W-1:0] pv [4] = '{8'h20, 8'h40, 8'h02, 8'h04};
	logic [3:0] pe [4] = '{4'hb, 4'h7, 4'h1, 4'h2};

	dcp_port dut_u (.clk_i(clk_i), .rst_i(rst_i), .ref_clock_pos_i(ref_p),
		.ref_clock_neg_i(~ref_p), .adc_a_i(adc_a), .adc_b_i(adc_b),
		.tx_host_clock_i(hclk), .tx_data_i(hdata), .sleep_request_pin_i(pin),
		.reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wdata),
		.reg_rdata_o(rdata), .rx_data_o(rxd), .rx_forwarded_clock_o(fwd),
		.tx_word_a_o(txa), .tx_word_b_o(txb), .tx_pair_valid_o(tvalid),
		.tx_interp_2x_o(i2x), .pd_global_o(pg), .pd_light_sleep_o(pl),
		.rx_path_off_o(prx), .tx_path_off_o(ptx));

	dcp_host_model host_u (.run_i(run), .fwd_clk_i(fwd), .rx_data_i(rxd),
		.host_clk_o(hclk), .host_data_o(hdata), .cap_a_o(cap_a),
		.cap_b_o(cap_b), .rx_count_o(rx_count));

	initial
	begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end

	initial
	begin
		ref_p = 1'b0;
		ref_count = 0;
		forever #25 ref_p = ~ref_p;
	end

	always @(posedge ref_p)
		ref_count++;

	always @(posedge clk_i)
		if (tvalid === 1'b1)
			tx_count++;

	// ****************************************
	// tasks
	// ****************************************
	task automatic conclude;
		$display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			fail_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic tmo;
		fail_count++;
		$display("[ERR] t=%0t wait ran out got=%h exp=%h", $time, 0, 1);
		conclude();
	endtask

	task automatic wreg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] dv);
		@(posedge clk_i);
		wr <= 1'b1;
		addr <= a;
		wdata <= dv;
		@(posedge clk_i);
		wr <= 1'b0;
	endtask

	task automatic rreg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] dv);
		@(posedge clk_i);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk_i);
		rd <= 1'b0;
		#1;
		dv = rdata;
	endtask

	// waits for c more complete receive pairs
	task automatic rxw(input int c);
		int k, t;
		t = rx_count + c;
		k = 0;
		while (rx_count < t && k < 12 * c + 50)
		begin
			@(posedge clk_i);
			#1;
			k++;
		end
		if (rx_count < t)
			tmo();
	endtask

	task automatic txp(output logic [WORD_W-1:0] a, output logic [WORD_W-1:0] b);
		int k;
		k = 0;
		do
		begin
			@(posedge clk_i);
			#1;
			k++;
		end
		while (tvalid !== 1'b1 && k < 100);
		a = txa;
		b = txb;
		if (tvalid !== 1'b1)
			tmo();
	endtask

	// settle first: the forced-low clock may give one last edge
	task automatic pdchk(input logic [3:0] e);
		int rc, tc;
		repeat (10) @(posedge clk_i);
		#1;
		chk({12'h0, pg, pl, prx, ptx}, {12'h0, e});
		rc = rx_count;
		tc = tx_count;
		repeat (200) @(posedge clk_i);
		chk(16'(rx_count > rc), 16'(!e[1]));
		chk(16'(tx_count > tc), 16'(!e[0]));
	endtask

	// ****************************************
	// sequence
	// ****************************************
	initial
	begin
		rst_i = 1'b1;
		{pin, wr, rd, run} = 4'h0;
		addr = 10'h000;
		wdata = 8'h00;
		adc_a = 12'h800;
		adc_b = 12'h7ff;
		fail_count = 0;
		comparisons = 0;
		tx_count = 0;
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		for (int i = 0; i < 7; i++)
		begin
			rreg(offs[i], v);
			chk(v, RST_CFG);
			wreg(offs[i], 8'h5a + 8'(i));
			rreg(offs[i], v);
			chk(v, 8'h5a + 8'(i));
			wreg(offs[i], RST_CFG);
		end
		wreg(10'h3ff, 8'hff);
		rreg(10'h3ff, v);
		chk(v, 8'h00);
		wreg(OFS_INTERP, INTERP_2X);
		repeat (3) @(posedge clk_i);
		chk(i2x, 1'b1);
		wreg(OFS_INTERP, 8'h04);
		repeat (3) @(posedge clk_i);
		chk(i2x, 1'b0);
		run <= 1'b1;
		txp(a0, b0);
		chk(b0, 12'(~a0));
		for (int i = 0; i < 3; i++)
		begin
			txp(a1, b1);
			chk(a1, 12'(a0 + 12'h001));
			chk(b1, 12'(~a1));
			a0 = a1;
		end
		wreg(OFS_PAT_A, PAT_ZERO);
		rxw(3);
		chk(cap_a, 12'h800);
		chk(cap_b, 12'h7ff);
		wreg(OFS_TP_EN, TP_EN_VALUE);
		wreg(OFS_PAT_B, PAT_ONES);
		rxw(3);
		chk(cap_a, CODE_ZERO);
		chk(cap_b, CODE_ONES);
		wreg(OFS_PAT_A, PAT_TOGGLE);
		wreg(OFS_PAT_B, PAT_RAMP);
		rxw(3);
		a0 = cap_a;
		b0 = cap_b;
		rxw(1);
		chk(16'(a0 == CODE_ZERO || a0 == CODE_ONES), 16'h1);
		chk(cap_a, 12'(~a0));
		chk(cap_b, 12'(b0 + 12'h001));
		rxw(4095);
		chk(cap_b, b0);
		wreg(OFS_CUST_HI, 8'h29);
		wreg(OFS_CUST_LO, 8'h34);
		wreg(OFS_PAT_A, PAT_CUSTOM);
		wreg(OFS_PAT_B, PAT_CUSTOM);
		rxw(3);
		chk(cap_a, 12'ha4d);
		chk(cap_b, 12'ha4d);
		rxw(2);
		chk(cap_a, 12'ha4d);
		wreg(OFS_TP_EN, 8'h00);
		rxw(3);
		chk(cap_a, 12'h800);
		r = ref_count;
		n = rx_count;
		repeat (1000) @(posedge clk_i);
		d = (ref_count - r) - (rx_count - n);
		chk(16'(d >= -1 && d <= 1), 16'h1);
		for (int i = 0; i < 4; i++)
		begin
			wreg(OFS_PWRDN, pv[i]);
			pdchk(4'h0);
			pin <= 1'b1;
			pdchk(pe[i]);
			pin <= 1'b0;
			wreg(OFS_PWRDN, pv[i] | 8'h80);
			pdchk(pe[i]);
			wreg(OFS_PWRDN, pv[i]);
			pdchk(4'h0);
		end
		conclude();
	end
endmodule
